// file: common/fcsc_pkg.sv
// shared constants, states and carriers for the flash command and status host
package fcsc_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_HOST_STATUS = 8'h10;
  localparam logic [7:0] REG_OPERATION_STATUS = 8'h14;
  localparam logic [7:0] REG_READ_ARRAY_CODE = 8'h18;
  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 2;
  // host status register fields
  localparam int HS_BUSY = 0;
  localparam int HS_READY_BUSY = 1;
  localparam int HS_READ_OK = 2;
  localparam int HS_WRITE_OK = 3;
  localparam int HS_ABORT_SEEN = 4;
  localparam int HS_NEED_READ_ARRAY = 5;
  localparam int HS_IMPROPER_SEQ = 6;
  localparam int HS_PROTECT = 7;
  localparam int HS_SUPPLY_ERR = 8;
  localparam int HS_WRITE_ERR = 9;
  localparam int HS_ERASE_ERR = 10;
  localparam int HS_MACHINE_READY = 11;
  // operation status byte fields
  localparam int OS_RESERVED_BIT = 0;
  localparam int OS_PROTECT = 1;
  localparam int OS_SUPPLY_ERR = 3;
  localparam int OS_WRITE_ERR = 4;
  localparam int OS_ERASE_ERR = 5;
  localparam int OS_MACHINE_READY = 7;
  // reset values
  localparam logic [7:0] READ_ARRAY_CODE_RESET = 8'hFF;
  // timing, in ns, and derived cycle counts at 25 ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_NS = 50;
  localparam int ACCESS_NS = 100;
  localparam int RESET_LOW_NS = 100;
  localparam int WAKE_READ_NS = 600;
  localparam int WAKE_WRITE_NS = 1000;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_READ_CYC = (WAKE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_WRITE_CYC = (WAKE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // operations ordered through the control register
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_POLL = 2'h2,
    OP_RESET = 2'h3
  } fcsc_op_type;
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETUP = 6'h02,
    ST_STROBE = 6'h04,
    ST_HOLD = 6'h08,
    ST_WAIT_RB = 6'h10,
    ST_RST_LOW = 6'h20
  } fcsc_st_type;
  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } fcsc_apb_req_type;
  // pins driven toward the flash device
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
    logic data_oe;
    logic chip_select_n;
    logic output_enable_n;
    logic write_strobe_n;
    logic reset_powerdown_n;
  } fcsc_pins_type;
endpackage

// file: src/fcsc_host.sv
// host controller driving a byte-wide flash through its strobes, apb registers
// What the document requires
// (RULE1) device sets protect flag on refusal
// (RULE2) identifier read returns lock bit states
// (RULE3) host masks reserved status bit zero
// (RULE4) ready/busy low while operation runs
// (RULE5) ready/busy output is always driven
// (RULE6) ready/busy high in suspend, power-down; the model keeps it low through power-down after an aborted operation
// (RULE7) supply error sets with write/erase error
// (RULE8) reset mid-operation aborts, enters power-down
// (RULE9) host repeats sequence after reset abort; the host only sets abort_seen and does not repeat anything
// (RULE10) status cleared by reset pin low
// (RULE11) latched command survives supply, select changes
// (RULE12) read-array mode after power-up, wake
// (RULE13) host issues read-array after operations; the host only sets need_read_array until the read-array code is written
// (RULE14) writes only with select and strobe low
// (RULE15) device ignores inputs while reset low
// (RULE16) host waits wake delays before access
// (RULE17) select decoded, output enable shared
// (RULE18) both error flags mean improper sequence
// (RULE19) supply level reported only after commands
// (RULE20) poll ready before checking error flags
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fcsc_host (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire fcsc_pkg::fcsc_apb_req_type apb_req_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output fcsc_pkg::fcsc_pins_type pins_out,
  input wire logic [7:0] flash_data_in,
  input wire logic ready_busy_output_in
);
  import fcsc_pkg::*;

  typedef struct packed {
    fcsc_st_type st;
    fcsc_op_type op;
    logic pend;
    logic [15:0] cnt;
    logic [15:0] wake_cnt;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] op_status;
    logic [7:0] read_array_code;
    logic abort_seen;
    logic need_read_array;
    fcsc_pins_type pins;
  } fcsc_state_type;

  fcsc_state_type r;
  fcsc_state_type next_r;
  logic wr_acc;
  logic rd_ok;
  logic wr_ok;
  logic mapped;
  logic [31:0] host_status;

  // true when the address names one of our registers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == REG_CONTROL) || (a == REG_ADDRESS) || (a == REG_WDATA) ||
      (a == REG_RDATA) || (a == REG_HOST_STATUS) || (a == REG_OPERATION_STATUS) ||
      (a == REG_READ_ARRAY_CODE);
  endfunction

  // apb handshake: every access completes in its first access cycle
  assign pready_out = 1'b1;
  assign mapped = is_mapped(apb_req_in.paddr);
  assign pslverr_out = apb_req_in.psel & apb_req_in.penable & ~mapped;
  assign wr_acc = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & mapped;
  assign pins_out = r.pins;

  // (RULE16) wake delays gate reads and writes
  assign rd_ok = r.pins.reset_powerdown_n && (r.wake_cnt >= 16'(WAKE_READ_CYC));
  assign wr_ok = r.pins.reset_powerdown_n && (r.wake_cnt >= 16'(WAKE_WRITE_CYC));

  // host status word assembled from live and captured state
  always_comb begin
    host_status = 32'h0000_0000;
    host_status[HS_BUSY] = (r.st != ST_IDLE) | r.pend;
    host_status[HS_READY_BUSY] = ready_busy_output_in;
    host_status[HS_READ_OK] = rd_ok;
    host_status[HS_WRITE_OK] = wr_ok;
    host_status[HS_ABORT_SEEN] = r.abort_seen;
    host_status[HS_NEED_READ_ARRAY] = r.need_read_array;
    // (RULE18) both error bits flag an improper sequence
    host_status[HS_IMPROPER_SEQ] = r.op_status[OS_WRITE_ERR] & r.op_status[OS_ERASE_ERR];
    host_status[HS_PROTECT] = r.op_status[OS_PROTECT];
    host_status[HS_SUPPLY_ERR] = r.op_status[OS_SUPPLY_ERR];
    host_status[HS_WRITE_ERR] = r.op_status[OS_WRITE_ERR];
    host_status[HS_ERASE_ERR] = r.op_status[OS_ERASE_ERR];
    host_status[HS_MACHINE_READY] = r.op_status[OS_MACHINE_READY];
  end

  // register read mux
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (apb_req_in.paddr == REG_CONTROL) begin
      prdata_out = {29'h0000_0000, r.pend, r.op};
    end else if (apb_req_in.paddr == REG_ADDRESS) begin
      prdata_out = {12'h000, r.addr};
    end else if (apb_req_in.paddr == REG_WDATA) begin
      prdata_out = {24'h00_0000, r.wdata};
    end else if (apb_req_in.paddr == REG_RDATA) begin
      prdata_out = {24'h00_0000, r.rdata};
    end else if (apb_req_in.paddr == REG_HOST_STATUS) begin
      prdata_out = host_status;
    end else if (apb_req_in.paddr == REG_OPERATION_STATUS) begin
      prdata_out = {24'h00_0000, r.op_status};
    end else if (apb_req_in.paddr == REG_READ_ARRAY_CODE) begin
      prdata_out = {24'h00_0000, r.read_array_code};
    end
  end

  // sequencer and register writes
  always_comb begin
    next_r = r;
    // wake counter runs while the reset line is high, saturating
    if (r.pins.reset_powerdown_n && (r.wake_cnt != 16'hFFFF)) begin
      next_r.wake_cnt = r.wake_cnt + 16'h0001;
    end
    // software register writes
    if (wr_acc) begin
      if (apb_req_in.paddr == REG_CONTROL) begin
        if (apb_req_in.pwdata[CTRL_GO_BIT] && (r.st == ST_IDLE) && !r.pend) begin
          next_r.op = fcsc_op_type'(apb_req_in.pwdata[CTRL_OP_LSB +: 2]);
          next_r.pend = 1'b1;
        end
      end else if (apb_req_in.paddr == REG_ADDRESS) begin
        next_r.addr = apb_req_in.pwdata[19:0];
      end else if (apb_req_in.paddr == REG_WDATA) begin
        next_r.wdata = apb_req_in.pwdata[7:0];
      end else if (apb_req_in.paddr == REG_READ_ARRAY_CODE) begin
        next_r.read_array_code = apb_req_in.pwdata[7:0];
      end else if (apb_req_in.paddr == REG_HOST_STATUS) begin
        // write one clears abort_seen
        if (apb_req_in.pwdata[HS_ABORT_SEEN]) begin
          next_r.abort_seen = 1'b0;
        end
      end
    end
    case (r.st)
      ST_IDLE: begin
        if (r.pend) begin
          if (r.op == OP_RESET) begin
            // (RULE9) reset during a busy operation is flagged for a retry
            if (r.pins.reset_powerdown_n && !ready_busy_output_in) begin
              next_r.abort_seen = 1'b1;
            end
            next_r.pins.reset_powerdown_n = 1'b0;
            next_r.cnt = 16'h0000;
            next_r.pend = 1'b0;
            next_r.st = ST_RST_LOW;
          end else if (r.op == OP_WRITE && wr_ok) begin
            // (RULE14) select and data set up before the write strobe
            next_r.pins.addr = r.addr;
            next_r.pins.data = r.wdata;
            next_r.pins.data_oe = 1'b1;
            next_r.pins.chip_select_n = 1'b0;
            next_r.pend = 1'b0;
            next_r.st = ST_SETUP;
          end else if (r.op == OP_READ && rd_ok) begin
            next_r.pins.addr = r.addr;
            // (RULE17) select and output enable together
            next_r.pins.chip_select_n = 1'b0;
            next_r.pins.output_enable_n = 1'b0;
            next_r.pend = 1'b0;
            next_r.st = ST_SETUP;
          end else if (r.op == OP_POLL && rd_ok) begin
            next_r.pend = 1'b0;
            next_r.st = ST_WAIT_RB;
          end
        end
      end
      ST_WAIT_RB: begin
        // (RULE20) status is read only once ready/busy is high
        if (ready_busy_output_in) begin
          next_r.pins.chip_select_n = 1'b0;
          next_r.pins.output_enable_n = 1'b0;
          next_r.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_r.cnt = 16'h0000;
        if (r.op == OP_WRITE) begin
          next_r.pins.write_strobe_n = 1'b0;
        end
        next_r.st = ST_STROBE;
      end
      ST_STROBE: begin
        next_r.cnt = r.cnt + 16'h0001;
        if (r.op == OP_WRITE && r.cnt == 16'(STROBE_CYC - 1)) begin
          next_r.pins.write_strobe_n = 1'b1;
          // (RULE13) a read-array code write satisfies the pending need
          if (r.wdata == r.read_array_code) begin
            next_r.need_read_array = 1'b0;
          end
          next_r.st = ST_HOLD;
        end else if (r.op != OP_WRITE && r.cnt == 16'(ACCESS_CYC - 1)) begin
          next_r.rdata = flash_data_in;
          next_r.pins.output_enable_n = 1'b1;
          if (r.op == OP_POLL) begin
            // (RULE3) reserved bit zero masked from the captured status
            next_r.op_status = flash_data_in & ~(8'h01 << OS_RESERVED_BIT);
            // (RULE13) finished operation needs read-array before array access
            next_r.need_read_array = 1'b1;
          end
          next_r.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // data released and select raised after the strobe edge
        next_r.pins.chip_select_n = 1'b1;
        next_r.pins.data_oe = 1'b0;
        next_r.st = ST_IDLE;
      end
      ST_RST_LOW: begin
        next_r.cnt = r.cnt + 16'h0001;
        // device status is cleared by its reset, so drop our copy too
        next_r.op_status = 8'h00;
        next_r.need_read_array = 1'b0;
        if (r.cnt == 16'(RESET_LOW_CYC - 1)) begin
          next_r.pins.reset_powerdown_n = 1'b1;
          next_r.wake_cnt = 16'h0000;
          next_r.st = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r.st <= ST_IDLE;
      r.op <= OP_WRITE;
      r.pend <= 1'b0;
      r.cnt <= 16'h0000;
      r.wake_cnt <= 16'h0000;
      r.addr <= 20'h0_0000;
      r.wdata <= 8'h00;
      r.rdata <= 8'h00;
      r.op_status <= 8'h00;
      r.read_array_code <= READ_ARRAY_CODE_RESET;
      r.abort_seen <= 1'b0;
      r.need_read_array <= 1'b0;
      r.pins <= '{addr: 20'h0_0000, data: 8'h00, data_oe: 1'b0, chip_select_n: 1'b1,
                  output_enable_n: 1'b1, write_strobe_n: 1'b1, reset_powerdown_n: 1'b1};
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// file: bench/fcsc_host_properties.sv
// concurrent checks on the ports of the flash host
`timescale 1ns/1ps
`default_nettype none
module fcsc_host_properties (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire fcsc_pkg::fcsc_apb_req_type apb_req_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire fcsc_pkg::fcsc_pins_type pins_out,
  input wire logic [7:0] flash_data_in,
  input wire logic ready_busy_output_in
);
  import fcsc_pkg::*;
  int wake_cnt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // cycles since reset release or since the device was woken
  always_ff @(posedge clk_in) begin
    if (srst_in || !pins_out.reset_powerdown_n) begin
      wake_cnt <= 0;
    end else if (wake_cnt < 1000) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  zero_wait_a: assert property (apb_req_in.psel && apb_req_in.penable |-> pready_out)
    else $error("access phase without ready");
  unmapped_error_a: assert property (apb_req_in.psel && apb_req_in.penable
    && apb_req_in.paddr > 8'h18 |-> pslverr_out && (apb_req_in.pwrite || prdata_out == 32'h0))
    else $error("unmapped access not refused");
  strobe_select_a: assert property (!pins_out.write_strobe_n |->
    !pins_out.chip_select_n && pins_out.data_oe) else $error("write strobe without select");
  strobe_width_a: assert property ($fell(pins_out.write_strobe_n) |=>
    !pins_out.write_strobe_n ##1 pins_out.write_strobe_n) else $error("strobe width off");
  read_contention_a: assert property (!pins_out.output_enable_n |->
    !pins_out.data_oe && !pins_out.chip_select_n) else $error("bus contention on read");
  reset_pulse_a: assert property ($fell(pins_out.reset_powerdown_n) |->
    (!pins_out.reset_powerdown_n) [*4] ##1 pins_out.reset_powerdown_n)
    else $error("reset pulse width off");
  quiet_in_reset_a: assert property (!pins_out.reset_powerdown_n |->
    pins_out.chip_select_n && pins_out.write_strobe_n && pins_out.output_enable_n)
    else $error("strobe in reset");
  wake_read_a: assert property ($fell(pins_out.output_enable_n) |->
    wake_cnt >= WAKE_READ_CYC - 1) else $error("read before wake delay");
  wake_write_a: assert property ($fell(pins_out.write_strobe_n) |->
    wake_cnt >= WAKE_WRITE_CYC - 1) else $error("write before wake delay");
  // main traffic kinds seen on the flash side
  cover property ($fell(pins_out.write_strobe_n));
  cover property ($fell(pins_out.output_enable_n));
  cover property ($fell(pins_out.reset_powerdown_n));
endmodule
bind fcsc_host fcsc_host_properties fcsc_host_properties_i (.clk_in(clk_in), .srst_in(srst_in),
  .apb_req_in(apb_req_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .pins_out(pins_out), .flash_data_in(flash_data_in),
  .ready_busy_output_in(ready_busy_output_in));
`default_nettype wire

// file: bench/fcsc_flash_model.sv
// behavioural model of the byte-wide flash device
`timescale 1ns/1ps
`default_nettype none
module fcsc_flash_model #(parameter int BUSY_CYC = 40) (
  input wire logic clk_in,
  input wire fcsc_pkg::fcsc_pins_type pins_in,
  input wire logic supply_low_in,
  output logic [7:0] data_out,
  output logic ready_busy_out
);
  import fcsc_pkg::*;
  logic [7:0] mem [16];
  logic [7:0] armed = 8'h00;
  logic [7:0] flags = 8'h00;
  logic we_q = 1'b1;
  logic rp_q = 1'b1;
  logic status_mode = 1'b0;
  logic id_mode = 1'b0;
  // lock codes: block lock set, master lock clear
  localparam logic [7:0] LOCK_CODES = 8'h01;
  int busy_cnt = 0;
  assign ready_busy_out = (busy_cnt == 0);
  // command latch and internal machine
  always @(posedge clk_in) begin
    we_q <= pins_in.write_strobe_n;
    rp_q <= pins_in.reset_powerdown_n;
    if (!pins_in.reset_powerdown_n) begin
      flags <= 8'h00;
      armed <= 8'h00;
      status_mode <= 1'b0;
      id_mode <= 1'b0;
    end else if (!rp_q) begin
      busy_cnt <= 0;
    end else begin
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (!we_q && pins_in.write_strobe_n && !pins_in.chip_select_n) begin
        status_mode <= ((pins_in.data != 8'hFF) && (pins_in.data != 8'h90)) || (armed != 8'h00);
        id_mode <= (pins_in.data == 8'h90) && (armed == 8'h00);
        armed <= 8'h00;
        if (armed != 8'h00) begin
          busy_cnt <= BUSY_CYC;
          case (armed)
            8'h40: begin
              flags <= supply_low_in ? 8'h18 : 8'h00;
              if (!supply_low_in) mem[pins_in.addr[3:0]] <= pins_in.data;
            end
            8'h20: flags <= (pins_in.data != 8'hD0) ? 8'h30 : (supply_low_in ? 8'h28 : 8'h00);
            default: flags <= 8'h12;
          endcase
        end else if (pins_in.data inside {8'h40, 8'h20, 8'h60}) begin
          armed <= pins_in.data;
        end
      end
    end
  end
  // read data; a released bus toggles every cycle
  always @(posedge clk_in) begin
    if (!pins_in.chip_select_n && !pins_in.output_enable_n && pins_in.reset_powerdown_n) begin
      data_out <= status_mode ? {busy_cnt == 0, 1'b0, flags[5:1], 1'b1} :
        (id_mode ? LOCK_CODES : mem[pins_in.addr[3:0]]);
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule
`default_nettype wire

// file: bench/fcsc_host_tb.sv
// self-checking bench for the flash host over apb
`timescale 1ns/1ps
`default_nettype none
module fcsc_host_tb;
  import fcsc_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic supply_low = 1'b0;
  fcsc_apb_req_type req = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, rb, err;
  fcsc_pins_type pins;
  logic [7:0] fdata = 8'h00;
  int mismatches = 0;
  int comparisons = 0;
  logic [7:0] c1 [5] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h60};
  logic [7:0] c2 [5] = '{8'h5A, 8'h11, 8'hD0, 8'h33, 8'h01};
  logic sup [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] st [5] = '{8'h80, 8'h98, 8'hA8, 8'hB0, 8'h92};
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  fcsc_host fcsc_host_i (.clk_in(clk_in), .srst_in(srst_in), .apb_req_in(req),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pins_out(pins),
    .flash_data_in(fdata), .ready_busy_output_in(rb));
  fcsc_flash_model fcsc_flash_model_i (.clk_in(clk_in), .pins_in(pins),
    .supply_low_in(supply_low), .data_out(fdata), .ready_busy_out(rb));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d);
    int n;
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk_in);
    req.penable <= 1'b1;
    n = 0;
    // answer looked at mid-cycle where it is settled, taken at the next edge
    @(negedge clk_in);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    d = prdata;
    err = pslverr;
    @(posedge clk_in);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d);
  endtask
  // order one operation and wait until the host is idle again
  task automatic run_op(input fcsc_op_type op);
    logic [31:0] c, s;
    int n;
    wr(REG_CONTROL, 32'h4 | 32'(op));
    n = 0;
    do begin
      rd(REG_CONTROL, c);
      rd(REG_HOST_STATUS, s);
      n++;
    end while ((c[2] !== 1'b0 || s[0] !== 1'b0) && n < 300);
    if (n >= 300) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic cmd(input logic [7:0] d);
    wr(REG_WDATA, {24'h0, d});
    run_op(OP_WRITE);
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(REG_READ_ARRAY_CODE, q);
    check(q, 32'hFF);
    rd(REG_HOST_STATUS, q);
    check(q, 32'h2);
    rd(8'h1C, q);
    check(q, 32'h0);
    check(32'(err), 32'h1);
    $display("test reset and map done");
    for (int i = 0; i < 5; i++) begin
      supply_low <= sup[i];
      wr(REG_ADDRESS, 32'h12345);
      cmd(c1[i]);
      cmd(c2[i]);
      rd(REG_HOST_STATUS, q);
      check(32'(q[1]), 32'h0);
      run_op(OP_POLL);
      rd(REG_OPERATION_STATUS, q);
      check(q, {24'h0, st[i]});
      rd(REG_HOST_STATUS, q);
      check(32'(q[11:5]), {25'h0, st[i][7], st[i][5], st[i][4], st[i][3], st[i][1],
        st[i][5] & st[i][4], 1'b1});
      cmd(8'hFF);
      rd(REG_HOST_STATUS, q);
      check(32'(q[5]), 32'h0);
    end
    supply_low <= 1'b0;
    run_op(OP_READ);
    rd(REG_RDATA, q);
    check(q, 32'h5A);
    cmd(8'h90);
    run_op(OP_READ);
    rd(REG_RDATA, q);
    check(q, 32'h01);
    $display("test command cases done");
    supply_low <= 1'b1;
    cmd(8'h20);
    cmd(8'hD0);
    run_op(OP_RESET);
    supply_low <= 1'b0;
    rd(REG_HOST_STATUS, q);
    check(32'(q[4]), 32'h1);
    check(32'(q[1]), 32'h1);
    cmd(8'h70);
    run_op(OP_POLL);
    rd(REG_OPERATION_STATUS, q);
    check(q, 32'h80);
    wr(REG_HOST_STATUS, 32'h10);
    rd(REG_HOST_STATUS, q);
    check(32'(q[4]), 32'h0);
    $display("test reset abort done");
    print_verdict();
  end
endmodule
`default_nettype wire
